/* include/pmsa_pkg.sv */
// ----------------------------------------------------------------
// Management view constants
// ----------------------------------------------------------------
package pmsa_pkg;

  // ----------------------------------------------------------------
  // 16-bit management register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] MII_IDX_BASIC_STAT = 5'h01;
  localparam logic [4:0] MII_IDX_IDENT_UPPER = 5'h02;
  localparam logic [4:0] MII_IDX_IDENT_LOWER = 5'h03;
  localparam logic [4:0] MII_IDX_NEG_OFFER = 5'h04;
  localparam logic [4:0] MII_IDX_PARTNER = 5'h05;

  // ----------------------------------------------------------------
  // 8-bit port register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_ADDR_CTRL = 8'h1C;
  localparam logic [7:0] PORT_ADDR_STAT0 = 8'h1E;
  localparam logic [7:0] PORT_ADDR_STAT1 = 8'h1F;

  // ----------------------------------------------------------------
  // Port control byte fields and reset
  // ----------------------------------------------------------------
  localparam int CTRL_NEG_EN_BIT = 7;
  localparam int CTRL_PAUSE_BIT = 4;
  localparam int CTRL_ABIL_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h9F;

  // ----------------------------------------------------------------
  // Port status byte fields
  // ----------------------------------------------------------------
  localparam int STAT0_DONE_BIT = 6;
  localparam int STAT0_LINK_BIT = 5;
  localparam int STAT1_FAULT_BIT = 0;

  // ----------------------------------------------------------------
  // 16-bit word fields
  // ----------------------------------------------------------------
  localparam int BS_DONE_BIT = 5;
  localparam int BS_FAULT_BIT = 4;
  localparam int BS_ABLE_BIT = 3;
  localparam int BS_LINK_BIT = 2;
  localparam logic [4:0] BS_FIXED_HI = 5'h0F;
  localparam int OFR_PAUSE_BIT = 10;
  localparam int OFR_ABIL_LSB = 5;
  localparam logic [4:0] OFR_SELECTOR = 5'h01;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Reset value of the partner abilities
  // ----------------------------------------------------------------
  localparam logic [4:0] PARTNER_RESET = 5'h00;

endpackage : pmsa_pkg

/* include/pmsa_view_if.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Shared storage handed to the read formatter
// ----------------------------------------------------------------
interface pmsa_view_if;
  logic [7:0] ctrl;
  logic done;
  logic link;
  logic fault;
  logic [4:0] partner;

  modport src (output ctrl, output done, output link, output fault,
               output partner);
  modport dst (input ctrl, input done, input link, input fault,
               input partner);
endinterface : pmsa_view_if

/* hw/pmsa_read_fmt.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Builds the 16-bit and 8-bit read views from one set of storage
// ----------------------------------------------------------------
module pmsa_read_fmt #(
  parameter logic [15:0] IDENT_UPPER = 16'hA5A5,
  parameter logic [15:0] IDENT_LOWER = 16'h5A5A
) (
  // Storage
  pmsa_view_if.dst view,
  // Read addresses
  input wire logic [4:0] mgmt_reg_index_i,
  input wire logic [7:0] port_addr_i,
  // Read data
  output logic [15:0] mii_word_o,
  output logic [7:0] port_byte_o
);

  always_comb begin
    mii_word_o = pmsa_pkg::WORD_ZERO;
    unique case (mgmt_reg_index_i)
      pmsa_pkg::MII_IDX_BASIC_STAT: begin
        mii_word_o[15:11] = pmsa_pkg::BS_FIXED_HI; // R1 R20
        mii_word_o[0] = 1'b0; // R6
        mii_word_o[pmsa_pkg::BS_DONE_BIT] = view.done; // R2
        mii_word_o[pmsa_pkg::BS_FAULT_BIT] = view.fault; // R3
        mii_word_o[pmsa_pkg::BS_ABLE_BIT] =
          view.ctrl[pmsa_pkg::CTRL_NEG_EN_BIT]; // R4
        mii_word_o[pmsa_pkg::BS_LINK_BIT] = view.link; // R5
      end
      pmsa_pkg::MII_IDX_IDENT_UPPER: mii_word_o = IDENT_UPPER; // R7
      pmsa_pkg::MII_IDX_IDENT_LOWER: mii_word_o = IDENT_LOWER; // R8
      pmsa_pkg::MII_IDX_NEG_OFFER: begin // R9
        mii_word_o[pmsa_pkg::OFR_PAUSE_BIT] =
          view.ctrl[pmsa_pkg::CTRL_PAUSE_BIT]; // R10
        mii_word_o[pmsa_pkg::OFR_ABIL_LSB +: 4] =
          view.ctrl[pmsa_pkg::CTRL_ABIL_LSB +: 4]; // R11 R12 R13 R14
        mii_word_o[4:0] = pmsa_pkg::OFR_SELECTOR; // R23
      end
      pmsa_pkg::MII_IDX_PARTNER: begin // R15
        mii_word_o[pmsa_pkg::OFR_PAUSE_BIT] = view.partner[4]; // R16
        mii_word_o[pmsa_pkg::OFR_ABIL_LSB +: 4] =
          view.partner[3:0]; // R17 R18 R19 R21
      end
      default: mii_word_o = pmsa_pkg::WORD_ZERO;
    endcase
  end

  always_comb begin
    port_byte_o = pmsa_pkg::BYTE_ZERO;
    unique case (port_addr_i)
      pmsa_pkg::PORT_ADDR_CTRL: port_byte_o = view.ctrl; // R22
      pmsa_pkg::PORT_ADDR_STAT0: begin
        port_byte_o[pmsa_pkg::STAT0_DONE_BIT] = view.done;
        port_byte_o[pmsa_pkg::STAT0_LINK_BIT] = view.link;
        port_byte_o[4:0] = view.partner;
      end
      pmsa_pkg::PORT_ADDR_STAT1:
        port_byte_o[pmsa_pkg::STAT1_FAULT_BIT] = view.fault;
      default: port_byte_o = pmsa_pkg::BYTE_ZERO;
    endcase
  end

endmodule : pmsa_read_fmt

/* hw/pmsa_regs.sv */
`timescale 1ns/1ps
// Contract
// [R1] Basic status bit 11 is read-only and always reads 1.
// [R2] Basic status bit 5 shows negotiation done; resets to 0.
// [R3] Basic status bit 4 shows far-end fault; resets to 0.
// [R4] Basic status bit 3 reflects the negotiation-enable control bit.
// [R5] Basic status bit 2 shows link up; resets to 0.
// [R6] Basic status bit 0 always reads 0.
// [R7] Index 2 reads the fixed upper identifier word.
// [R8] Index 3 reads the fixed lower identifier word.
// [R9] The offer register sits at index 4.
// [R10] Offer bit 10 is pause, read-write, resets to 1.
// [R11] Offer bit 8 is 100 full, read-write, resets to 1.
// [R12] Offer bit 7 is 100 half, read-write, resets to 1.
// [R13] Offer bit 6 is 10 full, read-write, resets to 1.
// [R14] Offer bit 5 is 10 half, read-write, resets to 1.
// [R15] The partner register sits at index 5, from the last negotiation.
// [R16] Partner bit 10 is pause, read-only, resets to 0.
// [R17] Partner bit 8 is 100 full, read-only, resets to 0.
// [R18] Partner bit 7 is 100 half, read-only, resets to 0.
// [R19] Partner bit 6 is 10 full, read-only, resets to 0.
// [R20] Basic status bits 14 to 12 read 1, bit 15 reads 0.
// [R21] Partner bit 5 is 10 half, read-only, resets to 0.
// [R22] Each field and its byte alias share one storage bit.
// [R23] Reserved and fixed bits ignore writes and read fixed values. A byte write to the control byte stores bits 6 and 5, which read back.
// [R24] Station writes offer first, then polls done before partner reads.
module pmsa_regs #(
  parameter logic [15:0] IDENT_UPPER = 16'hA5A5, // Arbitrary value
  parameter logic [15:0] IDENT_LOWER = 16'h5A5A // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // 16-bit management access
  input wire logic [4:0] mgmt_reg_index_i,
  input wire logic mii_rd_i,
  input wire logic mii_wr_i,
  input wire logic [15:0] mii_wdata_i,
  output logic [15:0] mii_rdata_o,
  output logic mii_rvalid_o,
  // 8-bit port register access
  input wire logic [7:0] port_addr_i,
  input wire logic port_rd_i,
  input wire logic port_wr_i,
  input wire logic [7:0] port_wdata_i,
  output logic [7:0] port_rdata_o,
  output logic port_rvalid_o,
  // Line state from the PHY
  input wire logic negotiation_done_i,
  input wire logic link_good_i,
  input wire logic far_end_fault_i,
  input wire logic [4:0] partner_abil_i,
  // Control toward the PHY
  output logic negotiation_able_o,
  output logic [4:0] offer_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic done;
    logic link;
    logic fault;
    logic [4:0] partner;
    logic [15:0] mii_rdata;
    logic mii_rvalid;
    logic [7:0] port_rdata;
    logic port_rvalid;
  } pmsa_state_t;

  pmsa_state_t st_ff;
  pmsa_state_t nxt_st;
  logic [15:0] mii_word;
  logic [7:0] port_byte;

  pmsa_view_if view ();

  assign view.ctrl = st_ff.ctrl;
  assign view.done = st_ff.done;
  assign view.link = st_ff.link;
  assign view.fault = st_ff.fault;
  assign view.partner = st_ff.partner;

  // ----------------------------------------------------------------
  // Read formatting
  // ----------------------------------------------------------------
  pmsa_read_fmt #(
    .IDENT_UPPER(IDENT_UPPER),
    .IDENT_LOWER(IDENT_LOWER)
  ) u_fmt (
    .view(view.dst),
    .mgmt_reg_index_i(mgmt_reg_index_i),
    .port_addr_i(port_addr_i),
    .mii_word_o(mii_word),
    .port_byte_o(port_byte)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Status mirrors follow the line every cycle
    nxt_st.done = negotiation_done_i; // R2
    nxt_st.link = link_good_i; // R5
    nxt_st.fault = far_end_fault_i; // R3
    // Partner abilities are caught when negotiation completes
    if (negotiation_done_i && !st_ff.done) begin
      nxt_st.partner = partner_abil_i; // R15
    end
    // Only the writable offer bits are taken from a 16-bit write
    if (mii_wr_i && mgmt_reg_index_i == pmsa_pkg::MII_IDX_NEG_OFFER) begin
      nxt_st.ctrl[pmsa_pkg::CTRL_PAUSE_BIT] =
        mii_wdata_i[pmsa_pkg::OFR_PAUSE_BIT]; // R10
      nxt_st.ctrl[pmsa_pkg::CTRL_ABIL_LSB +: 4] =
        mii_wdata_i[pmsa_pkg::OFR_ABIL_LSB +: 4]; // R11
    end
    // A byte write in the same cycle lands last
    if (port_wr_i && port_addr_i == pmsa_pkg::PORT_ADDR_CTRL) begin
      nxt_st.ctrl = port_wdata_i; // R22
    end
    nxt_st.mii_rvalid = mii_rd_i;
    nxt_st.port_rvalid = port_rd_i;
    nxt_st.mii_rdata = mii_rd_i ? mii_word : st_ff.mii_rdata;
    nxt_st.port_rdata = port_rd_i ? port_byte : st_ff.port_rdata;
    if (!reset_n_i) begin
      nxt_st.ctrl = pmsa_pkg::CTRL_RESET; // R4
      nxt_st.done = 1'b0;
      nxt_st.link = 1'b0;
      nxt_st.fault = 1'b0;
      nxt_st.partner = pmsa_pkg::PARTNER_RESET; // R21
      nxt_st.mii_rdata = pmsa_pkg::WORD_ZERO;
      nxt_st.mii_rvalid = 1'b0;
      nxt_st.port_rdata = pmsa_pkg::BYTE_ZERO;
      nxt_st.port_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mii_rdata_o = st_ff.mii_rdata;
  assign mii_rvalid_o = st_ff.mii_rvalid;
  assign port_rdata_o = st_ff.port_rdata;
  assign port_rvalid_o = st_ff.port_rvalid;
  assign negotiation_able_o = st_ff.ctrl[pmsa_pkg::CTRL_NEG_EN_BIT];
  assign offer_o = {st_ff.ctrl[pmsa_pkg::CTRL_PAUSE_BIT],
                    st_ff.ctrl[pmsa_pkg::CTRL_ABIL_LSB +: 4]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic rd_stat;
  logic rd_offer;
  logic rd_partner;
  logic wr_offer;
  assign rd_stat = mii_rd_i
                   && mgmt_reg_index_i == pmsa_pkg::MII_IDX_BASIC_STAT;
  assign rd_offer = mii_rd_i
                    && mgmt_reg_index_i == pmsa_pkg::MII_IDX_NEG_OFFER;
  assign rd_partner = mii_rd_i
                      && mgmt_reg_index_i == pmsa_pkg::MII_IDX_PARTNER;
  assign wr_offer = mii_wr_i
                    && mgmt_reg_index_i == pmsa_pkg::MII_IDX_NEG_OFFER;

  ten_half_a: assert property (rd_stat |=> mii_rdata_o[11]) // R1
    else $error("Basic status bit 11 not set");
  stat_high_a: assert property (rd_stat |=> mii_rdata_o[15:12] == 4'h7) // R20
    else $error("Basic status bits 15 to 12 wrong");
  ext_zero_a: assert property (rd_stat |=> !mii_rdata_o[0]) // R6
    else $error("Basic status bit 0 not zero");
  done_mirror_a: assert property ( // R2
    rd_stat ##1 mii_rvalid_o
    |-> mii_rdata_o[5] ==
        ($past(negotiation_done_i, 2) && $past(reset_n_i, 2))
  )
    else $error("Done bit does not follow the line");
  link_mirror_a: assert property ( // R5
    rd_stat |=> mii_rdata_o[2] ==
      ($past(link_good_i, 2) && $past(reset_n_i, 2))
  )
    else $error("Link bit does not follow the line");
  ident_upper_a: assert property ( // R7
    mii_rd_i && mgmt_reg_index_i == pmsa_pkg::MII_IDX_IDENT_UPPER
    |=> mii_rdata_o == IDENT_UPPER
  )
    else $error("Upper identifier wrong");
  offer_write_a: assert property ( // R10
    wr_offer && !port_wr_i ##1 rd_offer
    |=> mii_rdata_o[10:5] ==
        {$past(mii_wdata_i[10], 2), 1'b0, $past(mii_wdata_i[8:5], 2)}
  )
    else $error("Offer write not seen on read back");
  alias_byte_a: assert property ( // R22
    port_wr_i && port_addr_i == pmsa_pkg::PORT_ADDR_CTRL
    |=> negotiation_able_o == $past(port_wdata_i[7])
        && offer_o == $past(port_wdata_i[4:0])
  )
    else $error("Byte write not seen on the shared bits");
  selector_a: assert property (rd_offer |=> mii_rdata_o[4:0] == 5'h01) // R23
    else $error("Selector field not fixed");
  partner_catch_a: assert property ( // R16
    negotiation_done_i && !st_ff.done
    ##1 (!negotiation_done_i || st_ff.done) && rd_partner
    |=> mii_rdata_o[10] == $past(partner_abil_i[4], 2)
        && mii_rdata_o[8:5] == $past(partner_abil_i[3:0], 2)
  )
    else $error("Partner abilities not caught at done");

  offer_rt_c: cover property (wr_offer ##1 rd_offer);
  alias_c: cover property (
    port_wr_i && port_addr_i == pmsa_pkg::PORT_ADDR_CTRL ##1 rd_offer
  );
  partner_c: cover property (
    negotiation_done_i && !st_ff.done ##[1:4] rd_partner
  );

endmodule : pmsa_regs

/* test/pmsa_line_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-end line: negotiates after each restart
// ----------------------------------------------------------------
module pmsa_line_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Commands from the bench
  input wire logic restart_i,
  input wire logic [3:0] latency_i,
  input wire logic [4:0] peer_abil_i,
  // Line state
  output logic negotiation_done_o,
  output logic link_good_o,
  output logic [4:0] partner_abil_o
);
  logic busy;
  logic [3:0] cnt;
  logic [4:0] held;

  always @(posedge clk_i) begin
    if (!reset_n_i || restart_i) begin
      busy <= restart_i;
      cnt <= latency_i;
      negotiation_done_o <= 1'b0;
      link_good_o <= 1'b0;
      if (!reset_n_i) held <= 5'h00;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      negotiation_done_o <= 1'b1;
      link_good_o <= 1'b1;
      held <= peer_abil_i;
    end
  end
  // Abilities read as the inverse of the held value while negotiation is not done
  assign partner_abil_o = negotiation_done_o ? held : ~held;
endmodule : pmsa_line_model

/* test/test_phy_mgmt_status_autoneg_regs.sv */
`timescale 1ns/1ps
module test_phy_mgmt_status_autoneg_regs;
  localparam logic [15:0] IU = 16'h1234; // Arbitrary value
  localparam logic [15:0] IL = 16'h4321; // Arbitrary value
  logic clk_i, reset_n_i, mii_rd_i, mii_wr_i, port_rd_i, port_wr_i;
  logic [4:0] mgmt_reg_index_i, partner_abil_i, peer, offer_o, pm;
  logic [15:0] mii_wdata_i, mii_rdata_o;
  logic [7:0] port_addr_i, port_wdata_i, port_rdata_o, c;
  logic mii_rvalid_o, port_rvalid_o, negotiation_done_i, link_good_i;
  logic far_end_fault_i, negotiation_able_o, restart, dq;
  logic [3:0] lat;
  logic [31:0] r;
  logic [15:0] qw[$];
  logic [7:0] qb[$];
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 43912;
  int i, k;

  pmsa_regs #(.IDENT_UPPER(IU), .IDENT_LOWER(IL)) dut (.clk_i, .reset_n_i,
    .mgmt_reg_index_i, .mii_rd_i, .mii_wr_i, .mii_wdata_i, .mii_rdata_o,
    .mii_rvalid_o, .port_addr_i, .port_rd_i, .port_wr_i, .port_wdata_i,
    .port_rdata_o, .port_rvalid_o, .negotiation_done_i, .link_good_i,
    .far_end_fault_i, .partner_abil_i, .negotiation_able_o, .offer_o);
  pmsa_line_model line (.clk_i, .reset_n_i, .restart_i(restart),
    .latency_i(lat), .peer_abil_i(peer),
    .negotiation_done_o(negotiation_done_i),
    .link_good_o(link_good_i), .partner_abil_o(partner_abil_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Expected views
  // ----------------------------------------------------------------
  function automatic logic [15:0] ew(input logic [4:0] a);
    logic [4:0] p;
    p = (negotiation_done_i && !dq) ? partner_abil_i : pm;
    case (a)
      5'h01: ew = {5'h0F, 5'h00, negotiation_done_i, far_end_fault_i, c[7],
                   link_good_i, 2'h0};
      5'h02: ew = IU;
      5'h03: ew = IL;
      5'h04: ew = {5'h00, c[4], 1'b0, c[3:0], 5'h01};
      5'h05: ew = {5'h00, p[4], 1'b0, p[3:0], 5'h00};
      default: ew = 16'h0000;
    endcase
  endfunction : ew

  function automatic logic [7:0] eb(input logic [7:0] a);
    logic [4:0] p;
    p = (negotiation_done_i && !dq) ? partner_abil_i : pm;
    case (a)
      8'h1C: eb = c;
      8'h1E: eb = {1'b0, negotiation_done_i, link_good_i, p};
      8'h1F: eb = {7'h00, far_end_fault_i};
      default: eb = 8'h00;
    endcase
  endfunction : eb

  // Partner abilities as latched on a rising done
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      pm <= 5'h00;
      dq <= 1'b0;
    end else begin
      dq <= negotiation_done_i;
      if (negotiation_done_i && !dq) pm <= partner_abil_i;
    end
  end

  // ----------------------------------------------------------------
  // Compare, access and verdict tasks
  // ----------------------------------------------------------------
  task automatic cmp16(input string n, input logic [15:0] e, s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp16

  task automatic cmp8(input string n, input logic [7:0] e, s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp8

  task automatic acc16(input logic [4:0] a, input logic [15:0] d,
                       input logic rd, wr);
    @(posedge clk_i);
    mgmt_reg_index_i <= a;
    mii_wdata_i <= d;
    mii_rd_i <= rd;
    mii_wr_i <= wr;
    if (rd) qw.push_back(ew(a));
    if (wr && a == 5'h04) c = {c[7:5], d[10], d[8:5]};
    @(posedge clk_i);
    mii_rd_i <= 1'b0;
    mii_wr_i <= 1'b0;
    #1 cmp8("ctrl", {2'h0, c[7], c[4:0]},
            {2'h0, negotiation_able_o, offer_o});
  endtask : acc16

  task automatic acc8(input logic [7:0] a, d, input logic rd, wr);
    @(posedge clk_i);
    port_addr_i <= a;
    port_wdata_i <= d;
    port_rd_i <= rd;
    port_wr_i <= wr;
    if (rd) qb.push_back(eb(a));
    if (wr && a == 8'h1C) c = d;
    @(posedge clk_i);
    port_rd_i <= 1'b0;
    port_wr_i <= 1'b0;
    #1 cmp8("ctrl", {2'h0, c[7], c[4:0]},
            {2'h0, negotiation_able_o, offer_o});
  endtask : acc8

  // Write the offer by either path, read it back on the next cycle
  task automatic wr_rd(input logic bp, input logic [15:0] d);
    @(posedge clk_i);
    mgmt_reg_index_i <= 5'h04;
    mii_wdata_i <= d;
    port_addr_i <= 8'h1C;
    port_wdata_i <= d[7:0];
    mii_wr_i <= !bp;
    port_wr_i <= bp;
    c = bp ? d[7:0] : {c[7:5], d[10], d[8:5]};
    @(posedge clk_i);
    mii_wr_i <= 1'b0;
    port_wr_i <= 1'b0;
    mii_rd_i <= 1'b1;
    qw.push_back(ew(5'h04));
    @(posedge clk_i);
    mii_rd_i <= 1'b0;
  endtask : wr_rd

  // Read one index on every cycle for n cycles
  task automatic poll16(input logic [4:0] a, input int n);
    @(posedge clk_i);
    mgmt_reg_index_i <= a;
    mii_rd_i <= 1'b1;
    repeat (n) begin
      qw.push_back(ew(a));
      @(posedge clk_i);
    end
    mii_rd_i <= 1'b0;
  endtask : poll16

  task automatic do_reset();
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    c = 8'h9F;
  endtask : do_reset

  task give_verdict();
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Read answer watcher and cycle limit
  // ----------------------------------------------------------------
  always @(negedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
    if (mii_rvalid_o !== 1'b0 && qw.size() == 0)
      cmp8("mii_rvalid", 8'h00, {7'h00, mii_rvalid_o});
    else if (mii_rvalid_o !== 1'b0)
      cmp16("mii_rdata", qw.pop_front(), mii_rdata_o);
    if (port_rvalid_o !== 1'b0 && qb.size() == 0)
      cmp8("port_rvalid", 8'h00, {7'h00, port_rvalid_o});
    else if (port_rvalid_o !== 1'b0)
      cmp8("port_rdata", qb.pop_front(), port_rdata_o);
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {mii_rd_i, mii_wr_i, port_rd_i, port_wr_i} = 4'h0;
    {restart, far_end_fault_i, reset_n_i} = 3'h0;
    mgmt_reg_index_i = 5'h00;
    mii_wdata_i = 16'h0000;
    port_addr_i = 8'h00;
    port_wdata_i = 8'h00;
    lat = 4'h1;
    peer = 5'h00;
    for (k = 0; k < 2; k++) begin
      do_reset();
      for (i = 0; i < 8; i++) begin
        acc16(i[4:0], 16'hFFFF, 1'b1, 1'b0);
      end
      for (i = 28; i < 32; i++) acc8(i[7:0], 8'h00, 1'b1, 1'b0);
      for (i = 0; i < 40; i++) begin
        r = $random(seed);
        acc16({2'h0, r[2:0]}, r[31:16], 1'b1, 1'b1);
        acc8({5'h03, r[5:3]}, r[15:8], 1'b1, 1'b1);
        acc16(5'h01, 16'hFFFF, 1'b1, 1'b0);
      end
      r = $random(seed);
      wr_rd(1'b0, r[15:0]);
      wr_rd(1'b1, r[31:16]);
      acc16(5'h04, r[15:0], 1'b0, 1'b1);
      @(posedge clk_i);
      peer <= r[20:16];
      lat <= k ? 4'hC : 4'h1;
      restart <= 1'b1;
      @(posedge clk_i);
      restart <= 1'b0;
      for (i = 0; i < 40 && negotiation_done_i !== 1'b1; i++) @(posedge clk_i);
      far_end_fault_i <= r[21];
      repeat (2) @(posedge clk_i);
      acc16(5'h01, 16'h0000, 1'b1, 1'b0);
      acc16(5'h05, 16'hFFFF, 1'b1, 1'b1);
      acc8(8'h1E, 8'hFF, 1'b1, 1'b1);
      acc8(8'h1F, 8'hFF, 1'b1, 1'b0);
      // New partner abilities, polled on every cycle across the capture
      @(posedge clk_i);
      peer <= r[20:16] ^ 5'h0B;
      lat <= 4'h2;
      restart <= 1'b1;
      @(posedge clk_i);
      restart <= 1'b0;
      poll16(5'h05, 8);
      @(posedge clk_i);
      peer <= ~r[20:16];
      lat <= 4'hF;
      restart <= 1'b1;
      @(posedge clk_i);
      restart <= 1'b0;
      repeat (2) @(posedge clk_i);
      acc16(5'h05, 16'h0000, 1'b1, 1'b0);
      acc16(5'h01, 16'h0000, 1'b1, 1'b0);
    end
    repeat (3) @(posedge clk_i);
    if (qw.size() != 0 || qb.size() != 0) bad_count++;
    give_verdict();
  end
endmodule : test_phy_mgmt_status_autoneg_regs
